/* rtl/txmcd_cfg.svh */
// Constants for the transmit mode code descriptor control word block
//
// Contract
// - Access interrupt after valid mode command
// - Broadcast interrupt after valid broadcast command
// - Broadcast disable makes address 31 invalid
// - Force busy bit answers Busy
// - Busy suppresses mode data and pointer toggle
// - Reset terminal mode code ignores force busy
// - Set accessed flag at message completion
// - Accessed flag clears on resets or read
// - Pointer select picks buffer A or B
// - Toggle pointer select after error-free message
// - Resets clear pointer select to A
// - Indexed mode ignores pointer select
// - Host cannot write bits 8 to 11
// - Master clears word; soft reset clears three
`ifndef TXMCD_CFG_SVH
`define TXMCD_CFG_SVH

`define TXMCD_BIT_IWA      14
`define TXMCD_BIT_IBR      13
`define TXMCD_BIT_BUSY     12
`define TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG     11
`define TXMCD_BIT_DPB      10
`define TXMCD_BIT_BCAST    9
`define TXMCD_BIT_PPON     8
`define TXMCD_BIT_STOPP    3
`define TXMCD_BIT_PPEN     2
`define TXMCD_WORD_RESET   16'h0000
`define TXMCD_HOST_WMASK   16'hF00C
`define TXMCD_HOST_WMASK_X 16'hF008
`define TXMCD_DEV_MASK     16'h0F00
`define TXMCD_BCAST_ADDR   5'h1F
`define TXMCD_MC_RESET_RT  5'h08
`define TXMCD_MC_DATA_MSB  4

`endif

/* rtl/txmcd_pkg.sv */
// Types for the transmit mode code descriptor control word block
package txmcd_pkg;
   // Completed mode command as reported by the protocol engine
   typedef struct packed {
      logic       valid;
      logic [4:0] rt_addr;
      logic [4:0] mode_code;
      logic       error_free;
      logic       illegal;
   } txmcd_cmd_t;

   // Answer to the protocol engine for the command in progress
   typedef struct packed {
      logic busy;
      logic send_data;
      logic use_ptr_b;
      logic pingpong;
   } txmcd_resp_t;

   typedef enum logic [1:0] {
      TXMCD_IDLE,
      TXMCD_SERVE,
      TXMCD_DONE
   } txmcd_state_t;
endpackage

/* rtl/txmcd_resp.sv */
// Response decision for one mode command
`timescale 1ns/1ps
`include "txmcd_cfg.svh"
module txmcd_resp (
   // Command being served
   input  wire logic [4:0]  mode_code,
   input  wire logic        global_busy,
   input  wire logic [15:0] word,
   // Decision
   output logic             busy,
   output logic             send_data
);
   always_comb begin
      if (mode_code == `TXMCD_MC_RESET_RT) begin
         busy = 1'b0;
      end else begin
         busy = word[`TXMCD_BIT_BUSY] | global_busy;
      end
      send_data = mode_code[`TXMCD_MC_DATA_MSB] & ~busy;
   end
endmodule

/* rtl/txmcd_ctrl.sv */
// Transmit mode code descriptor control word with device-side updates
`timescale 1ns/1ps
`include "txmcd_cfg.svh"
module txmcd_ctrl (
   // Clock and resets
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  software_reset,
   // Host access port
   input  wire logic                  host_rd,
   input  wire logic                  host_wr,
   input  wire logic [15:0]           host_wdata,
   // Configuration
   input  wire logic                  terminal_execution_enable,
   input  wire logic                  broadcast_disable,
   input  wire logic                  global_busy,
   input  wire logic                  global_irq_access_en,
   input  wire logic                  global_irq_bcast_en,
   input  wire logic                  pointer_toggle_inhibit,
   input  wire logic                  pingpong_ack,
   // Protocol engine
   input  wire logic                  cmd_start,
   input  wire logic [4:0]            cmd_mode_code,
   input  wire txmcd_pkg::txmcd_cmd_t cmd_done,
   // Outputs
   output logic [15:0]                host_rdata,
   output txmcd_pkg::txmcd_resp_t     resp,
   output logic                       irq_pending,
   output logic                       irq,
   output logic                       log_access,
   output logic                       log_bcast,
   output logic                       cmd_accepted
);
   // =======================================================
   // State
   logic [15:0]             word_r;
   txmcd_pkg::txmcd_state_t state_r;
   logic                    busy_c;
   logic                    send_c;
   logic                    valid_c;
   logic                    bcast_c;
   logic                    ack_r;

   // =======================================================
   // Response decision
   txmcd_resp u_resp (
      .mode_code   (cmd_mode_code),
      .global_busy (global_busy),
      .word        (word_r),
      .busy        (busy_c),
      .send_data   (send_c)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         resp <= '0;
      end else if (cmd_start) begin
         resp.busy      <= busy_c;
         resp.send_data <= send_c;
         resp.use_ptr_b <= word_r[`TXMCD_BIT_DPB];
         resp.pingpong  <= word_r[`TXMCD_BIT_PPEN] & pingpong_ack;
      end
   end

   // Broadcast to 31 is invalid when broadcast is disabled
   always_comb begin
      bcast_c = cmd_done.rt_addr == `TXMCD_BCAST_ADDR;
      valid_c = cmd_done.valid & ~(bcast_c & broadcast_disable);
   end

   // =======================================================
   // Sequence
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= txmcd_pkg::TXMCD_IDLE;
      end else begin
         unique case (state_r)
            txmcd_pkg::TXMCD_IDLE: begin
               if (cmd_start) begin
                  state_r <= txmcd_pkg::TXMCD_SERVE;
               end
            end
            txmcd_pkg::TXMCD_SERVE: begin
               if (cmd_done.valid) begin
                  state_r <= txmcd_pkg::TXMCD_DONE;
               end
            end
            txmcd_pkg::TXMCD_DONE: begin
               state_r <= txmcd_pkg::TXMCD_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // Control word
   always_ff @(posedge mclk) begin
      if (rst) begin
         word_r <= `TXMCD_WORD_RESET;
      end else if (software_reset) begin
         word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG]  <= 1'b0;
         word_r[`TXMCD_BIT_DPB]   <= 1'b0;
         word_r[`TXMCD_BIT_BCAST] <= 1'b0;
      end else begin
         if (host_wr) begin
            if (terminal_execution_enable) begin
               word_r <= (word_r & ~`TXMCD_HOST_WMASK_X) | (host_wdata & `TXMCD_HOST_WMASK_X);
            end else begin
               word_r <= (word_r & ~`TXMCD_HOST_WMASK) | (host_wdata & `TXMCD_HOST_WMASK);
            end
         end
         word_r[`TXMCD_BIT_PPON] <= word_r[`TXMCD_BIT_PPEN] & pingpong_ack;
         if (host_rd) begin
            word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG] <= 1'b0;
         end
         if (valid_c && state_r == txmcd_pkg::TXMCD_SERVE) begin
            word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG] <= 1'b1;
            if (bcast_c) begin
               word_r[`TXMCD_BIT_BCAST] <= 1'b1;
            end
            if (resp.pingpong && cmd_done.error_free && !resp.busy) begin
               word_r[`TXMCD_BIT_DPB] <= ~word_r[`TXMCD_BIT_DPB];
            end else if (resp.pingpong && !pointer_toggle_inhibit && !resp.busy) begin
               word_r[`TXMCD_BIT_DPB] <= ~word_r[`TXMCD_BIT_DPB];
            end
         end
      end
   end

   // =======================================================
   // Interrupts and log strobes
   always_ff @(posedge mclk) begin
      if (rst) begin
         log_access  <= 1'b0;
         log_bcast   <= 1'b0;
         irq_pending <= 1'b0;
         irq         <= 1'b0;
      end else begin
         log_access <= valid_c && state_r == txmcd_pkg::TXMCD_SERVE
                       && global_irq_access_en && word_r[`TXMCD_BIT_IWA];
         log_bcast  <= valid_c && state_r == txmcd_pkg::TXMCD_SERVE && bcast_c
                       && global_irq_bcast_en && word_r[`TXMCD_BIT_IBR];
         if (log_access || log_bcast) begin
            irq_pending <= 1'b1;
            irq         <= 1'b1;
         end else if (software_reset) begin
            irq_pending <= 1'b0;
            irq         <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         host_rdata   <= '0;
         ack_r        <= 1'b0;
         cmd_accepted <= 1'b0;
      end else begin
         host_rdata   <= word_r;
         ack_r        <= cmd_start;
         cmd_accepted <= ack_r;
      end
   end

   // =======================================================
   // Checks
   // master reset zero
   AST_MR_ZERO: assert property (@(posedge mclk) rst |=> word_r == `TXMCD_WORD_RESET)
      else $error("word not cleared by master reset");
   AST_RD_CLR: assert property (@(posedge mclk) disable iff (rst)
      host_rd && !(valid_c && state_r == txmcd_pkg::TXMCD_SERVE) && !software_reset
      |=> !word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG]) else $error("accessed flag kept after read");
   AST_SR_CLR: assert property (@(posedge mclk) disable iff (rst)
      software_reset |=> !word_r[`TXMCD_BIT_DPB] && !word_r[`TXMCD_BIT_BCAST])
      else $error("soft reset left bits");
   AST_DESCRIPTOR_ACCESSED_FLAG_SET: assert property (@(posedge mclk) disable iff (rst)
      valid_c && state_r == txmcd_pkg::TXMCD_SERVE && !software_reset
      |=> word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG]) else $error("accessed flag not set");
   AST_IWA: assert property (@(posedge mclk) disable iff (rst)
      valid_c && state_r == txmcd_pkg::TXMCD_SERVE && global_irq_access_en
      && word_r[`TXMCD_BIT_IWA] |=> log_access ##1 irq) else $error("no access irq");
   AST_IBR_OFF: assert property (@(posedge mclk) disable iff (rst)
      broadcast_disable && cmd_done.rt_addr == `TXMCD_BCAST_ADDR |=> !log_bcast)
      else $error("broadcast irq while disabled");
   AST_BUSY: assert property (@(posedge mclk) disable iff (rst)
      cmd_start && word_r[`TXMCD_BIT_BUSY] && cmd_mode_code != `TXMCD_MC_RESET_RT
      |=> resp.busy) else $error("force busy ignored");
   AST_MC8: assert property (@(posedge mclk) disable iff (rst)
      cmd_start && cmd_mode_code == `TXMCD_MC_RESET_RT |=> !resp.busy)
      else $error("reset mode code answered busy");
   AST_NODATA: assert property (@(posedge mclk) disable iff (rst)
      resp.busy |-> !resp.send_data) else $error("data sent while busy");
   AST_DPB_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !resp.pingpong && !software_reset |=> $stable(word_r[`TXMCD_BIT_DPB]))
      else $error("pointer moved outside ping-pong");

   // status bits out of host reach
   AST_HOST_RO: assert property (@(posedge mclk) disable iff (rst)
      host_wr && !host_rd && !software_reset
      && !(valid_c && state_r == txmcd_pkg::TXMCD_SERVE)
      |=> $stable(word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG:`TXMCD_BIT_BCAST]))
      else $error("host write reached status bits");

   AST_PPEN_LOCK: assert property (@(posedge mclk) disable iff (rst)
      host_wr && terminal_execution_enable && !software_reset
      |=> $stable(word_r[`TXMCD_BIT_PPEN]))
      else $error("mode bit written during execution");

   AST_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
      valid_c && state_r == txmcd_pkg::TXMCD_SERVE && resp.pingpong && !resp.busy
      && cmd_done.error_free && !software_reset
      |=> word_r[`TXMCD_BIT_DPB] != $past(word_r[`TXMCD_BIT_DPB]))
      else $error("pointer not inverted");

   AST_INHIBIT: assert property (@(posedge mclk) disable iff (rst)
      valid_c && state_r == txmcd_pkg::TXMCD_SERVE && pointer_toggle_inhibit
      && !cmd_done.error_free && !software_reset
      |=> $stable(word_r[`TXMCD_BIT_DPB]))
      else $error("pointer moved after failed message");

   AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (rst)
      resp.busy && !software_reset |=> $stable(word_r[`TXMCD_BIT_DPB]))
      else $error("pointer moved while busy");

   AST_SEND: assert property (@(posedge mclk) disable iff (rst)
      cmd_start && cmd_mode_code[`TXMCD_MC_DATA_MSB] && !global_busy
      && !word_r[`TXMCD_BIT_BUSY] |=> resp.send_data)
      else $error("mode data withheld");

   AST_IBR: assert property (@(posedge mclk) disable iff (rst)
      valid_c && state_r == txmcd_pkg::TXMCD_SERVE && bcast_c && global_irq_bcast_en
      && word_r[`TXMCD_BIT_IBR] |=> log_bcast ##1 irq)
      else $error("no broadcast irq");

   AST_SR_DESCRIPTOR_ACCESSED_FLAG: assert property (@(posedge mclk) disable iff (rst)
      software_reset |=> !word_r[`TXMCD_BIT_DESCRIPTOR_ACCESSED_FLAG])
      else $error("accessed flag kept after soft reset");

   AST_IRQ_HOLD: assert property (@(posedge mclk) disable iff (rst)
      irq && !software_reset |=> irq)
      else $error("interrupt dropped");

   AST_LOG_ONLY: assert property (@(posedge mclk) disable iff (rst)
      !(valid_c && state_r == txmcd_pkg::TXMCD_SERVE) |=> !log_access)
      else $error("access log without completion");

   AST_PTR: assert property (@(posedge mclk) disable iff (rst)
      cmd_start |=> resp.use_ptr_b == $past(word_r[`TXMCD_BIT_DPB]))
      else $error("wrong buffer pointer reported");

   AST_INDEXED: assert property (@(posedge mclk) disable iff (rst)
      cmd_start && !word_r[`TXMCD_BIT_PPEN] |=> !resp.pingpong)
      else $error("ping-pong used in indexed mode");

   AST_SR_KEEP: assert property (@(posedge mclk) disable iff (rst)
      software_reset |=> $stable(word_r[`TXMCD_BIT_IWA:`TXMCD_BIT_BUSY]))
      else $error("soft reset touched host bits");

   COV_IRQ: cover property (@(posedge mclk) log_access);
   COV_BUSY: cover property (@(posedge mclk) resp.busy);
   COV_BC: cover property (@(posedge mclk) log_bcast);
   COV_TOG: cover property (@(posedge mclk) $changed(word_r[`TXMCD_BIT_DPB]));
endmodule

/* tb/txmcd_bc_model.sv */
// Bus controller model that issues mode commands to the block
`timescale 1ns/1ps
module txmcd_bc_model (
   // Clock
   input  wire logic              mclk,
   // Command side
   output logic                   cmd_start,
   output logic [4:0]             cmd_mode_code,
   output txmcd_pkg::txmcd_cmd_t  cmd_done
);
   // ==========================================
   // Command sequencing
   initial begin
      cmd_start = 1'b0;
      cmd_mode_code = 5'h00;
      cmd_done = '0;
   end

   // Start, serve, complete, then idle gap before the next start
   task automatic issue(input logic [4:0] mc, input logic [4:0] ta, input logic ef);
      @(negedge mclk);
      cmd_start = 1'b1;
      cmd_mode_code = mc;
      @(negedge mclk);
      cmd_start = 1'b0;
      // Released lines flip so a stale code is never read
      cmd_mode_code = ~mc;
      @(negedge mclk);
      cmd_done = {1'b1, ta, mc, ef, ~ef};
      @(negedge mclk);
      cmd_done = {1'b0, ~ta, ~mc, 2'b00};
      repeat (2) @(negedge mclk);
   endtask
endmodule

/* tb/tb_rt_tx_mode_code_descriptor_ctrl.sv */
// Self-checking bench for the transmit mode code control word
`timescale 1ns/1ps
module tb_rt_tx_mode_code_descriptor_ctrl;
   // ==========================================
   // Signals
   logic mclk = 0, rst = 1, software_reset = 0, host_rd = 0, host_wr = 0;
   logic [15:0] host_wdata = 16'h0000;
   logic terminal_execution_enable = 0, broadcast_disable = 0, global_busy = 0;
   logic global_irq_access_en = 0, global_irq_bcast_en = 0;
   logic pointer_toggle_inhibit = 0, pingpong_ack = 0, cmd_start, d;
   logic [4:0] cmd_mode_code;
   txmcd_pkg::txmcd_cmd_t cmd_done;
   txmcd_pkg::txmcd_resp_t resp;
   logic [15:0] host_rdata, w;
   logic irq_pending, irq, log_access, log_bcast, cmd_accepted;
   int bad_count = 0, comparisons = 0, cycles = 0, acc_n = 0, bc_n = 0, ca_n = 0;

   txmcd_ctrl dut (.mclk, .rst, .software_reset, .host_rd, .host_wr, .host_wdata,
      .terminal_execution_enable, .broadcast_disable, .global_busy,
      .global_irq_access_en, .global_irq_bcast_en, .pointer_toggle_inhibit,
      .pingpong_ack, .cmd_start, .cmd_mode_code, .cmd_done, .host_rdata, .resp,
      .irq_pending, .irq, .log_access, .log_bcast, .cmd_accepted);
   txmcd_bc_model bc (.mclk, .cmd_start, .cmd_mode_code, .cmd_done);

   always #10 mclk = ~mclk;

   // Log pulses last one cycle, so count them; hang guard
   always @(posedge mclk) begin
      cycles++;
      if (log_access === 1'b1) acc_n++;
      if (log_bcast === 1'b1) bc_n++;
      if (cmd_accepted === 1'b1) ca_n++;
      if (cycles == 2000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ==========================================
   // Helpers
   task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   task automatic wr(input logic [15:0] v);
      host_wdata = v;
      pulse(host_wr);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_host_access;
      check("reset word", host_rdata, 16'h0000);
      wr(16'hFFFF);
      check("wr idle", host_rdata, 16'hF00C);
      terminal_execution_enable = 1'b1;
      pingpong_ack = 1'b1;
      wr(16'h4000);
      check("wr exec", host_rdata, 16'h4104);
   endtask

   task automatic t_pingpong;
      global_irq_access_en = 1'b1;
      bc.issue(5'h12, 5'h05, 1'b1);
      check("send", 16'(resp.send_data), 16'h0001);
      check("ptr a", 16'(resp.use_ptr_b), 16'h0000);
      check("word1", host_rdata, 16'h4D04);
      check("irq", 16'(irq), 16'h0001);
      check("irq pend", 16'(irq_pending), 16'h0001);
      bc.issue(5'h02, 5'h05, 1'b1);
      check("ptr b", 16'(resp.use_ptr_b), 16'h0001);
      check("word2", host_rdata, 16'h4904);
      check("acc log", 16'(acc_n), 16'h0002);
      pulse(host_rd);
      check("read clr", host_rdata, 16'h4104);
   endtask

   task automatic t_busy;
      wr(16'h5004);
      bc.issue(5'h11, 5'h05, 1'b1);
      check("busy", 16'(resp.busy), 16'h0001);
      check("no data", 16'(resp.send_data), 16'h0000);
      check("busy word", host_rdata, 16'h5904);
      bc.issue(5'h08, 5'h05, 1'b1);
      check("mc8 busy", 16'(resp.busy), 16'h0000);
      check("mc8 word", host_rdata, 16'h5D04);
   endtask

   task automatic t_bcast;
      wr(16'h2004);
      global_irq_bcast_en = 1'b1;
      bc.issue(5'h01, 5'h1F, 1'b1);
      check("bc log", 16'(bc_n), 16'h0001);
      broadcast_disable = 1'b1;
      bc.issue(5'h01, 5'h1F, 1'b1);
      check("bc off", 16'(bc_n), 16'h0001);
      broadcast_disable = 1'b0;
   endtask

   task automatic t_inhibit_soft;
      pointer_toggle_inhibit = 1'b1;
      d = host_rdata[10];
      bc.issue(5'h03, 5'h05, 1'b0);
      check("inhibit", 16'(host_rdata[10]), 16'(d));
      w = host_rdata;
      pulse(software_reset);
      check("soft word", host_rdata, w & 16'hF1FF);
      check("soft ptr", 16'(host_rdata[10]), 16'h0000);
      check("soft irq", 16'(irq), 16'h0000);
      check("soft pend", 16'(irq_pending), 16'h0000);
      check("accepted", 16'(ca_n), 16'h0007);
   endtask

   initial begin
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      t_host_access();
      t_pingpong();
      t_busy();
      t_bcast();
      t_inhibit_soft();
      report_and_stop();
   end
endmodule
